// *** core/pm_guard_pkg.sv ***
/*
  Shared types and constants for the program-memory write guard.
  Assumes word addressing of program memory, 512-word pages and
  configuration words that sit in the last implemented page.
*/
package pm_guard_pkg;

  localparam int ADDR_W = 24;
  localparam int PAGE_SHIFT = 9;
  localparam int PAGE_SEL_W = 9;
  localparam int PAGE_IDX_W = ADDR_W - PAGE_SHIFT;

  typedef logic [PAGE_IDX_W-1:0] page_idx_t;

  // Configuration word image; every flag bit except segment_direction and segment_protect_disable is active when programmed to 0, page select is a page number
  typedef struct packed {
    logic global_code_protect;
    logic global_write_protect;
    logic segment_protect_disable;
    logic segment_direction;
    logic last_page_guard;
    logic [PAGE_SEL_W-1:0] segment_page_select;
  } cfg_s;

  localparam int CFG_W = $bits(cfg_s);

  // Program-memory access presented by the memory controller
  typedef struct packed {
    logic valid;
    logic external;
    logic read;
    logic [ADDR_W-1:0] addr;
  } req_s;

  // Reset image is the erased, unprogrammed state
  localparam cfg_s CFG_RESET = '{
    global_code_protect: 1'b1,
    global_write_protect: 1'b1,
    segment_protect_disable: 1'b1,
    segment_direction: 1'b1,
    last_page_guard: 1'b1,
    segment_page_select: 9'h1FF
  };
  localparam cfg_s SHADOW_RESET = ~CFG_RESET;
  localparam logic [CFG_W-1:0] SHADOW_MATCH = {CFG_W{1'b1}};

  localparam page_idx_t LAST_PAGE_DEFAULT = 15'h01FF;

endpackage

// *** core/program_memory_write_guard.sv ***
/*
  Program-memory write guard: decides per access whether program memory
  may be read, written or erased, and watches the configuration image
  against its complementary shadow.
  Assumes the memory controller holds REQ stable while valid, and that
  the system turns FORCE_RESET into a device reset that drives NRST low.
*/
// Function
// - Code protect blocks external program accesses only
// - Write protect at 0 blocks internal writes
// - Writes inside protected segment are blocked
// - Block is OR of global and segment
// - Segment active only when disable bit 0
// - Selected 512-word page always inside segment
// - Direction 0 protects zero through page
// - Direction 1 protects page through last
// - Guard at 0 protects last page always
// - Both disables set leaves only global protection
// - Complementary shadow compared every cycle
// - Shadow mismatch after a load flags error, forces reset
// - Configuration source covered by same protection
`timescale 1ns/10ps
module program_memory_write_guard #(
  parameter pm_guard_pkg::page_idx_t LAST_PAGE = pm_guard_pkg::LAST_PAGE_DEFAULT
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic CFG_LOAD,
  input wire pm_guard_pkg::cfg_s CFG_WORD,
  input wire pm_guard_pkg::cfg_s CFG_UPSET,
  input wire pm_guard_pkg::req_s REQ,
  output logic BLOCK,
  output logic CFG_VALID,
  output pm_guard_pkg::cfg_s CFG_ACTIVE,
  output logic PARITY_ERROR,
  output logic FORCE_RESET
);
  import pm_guard_pkg::*;

  cfg_s cfg_active;
  cfg_s cfg_shadow;
  logic cfg_loaded;
  logic parity_error;
  cfg_s next_cfg_active;
  cfg_s next_cfg_shadow;
  logic next_cfg_loaded;
  logic next_parity_error;
  logic mismatch;

  // Page number of a word address
  function automatic page_idx_t page_of(input logic [ADDR_W-1:0] addr);
    page_of = addr[ADDR_W-1:PAGE_SHIFT];
  endfunction

  // Segment hit for a page under a given configuration
  function automatic logic segment_hit(input cfg_s c, input page_idx_t pg, input page_idx_t last);
    page_idx_t sel;
    logic in_seg;
    sel = page_idx_t'(c.segment_page_select);
    in_seg = 1'b0;
    if (!c.segment_protect_disable) begin
      if (c.segment_direction) begin
        in_seg = (pg >= sel);
      end else begin
        in_seg = (pg <= sel);
      end
    end
    // Guard covers the configuration words whatever the segment says
    segment_hit = in_seg | (!c.last_page_guard && pg == last);
  endfunction

  // Configuration image and shadow
  always_comb begin
    next_cfg_active = cfg_active ^ CFG_UPSET;
    next_cfg_shadow = cfg_shadow;
    next_cfg_loaded = cfg_loaded;
    if (CFG_LOAD) begin
      next_cfg_active = CFG_WORD;
      next_cfg_shadow = ~CFG_WORD;
      next_cfg_loaded = 1'b1;
    end
  end

  // Shadow check; a load rewrites both copies so it cannot trip itself
  assign mismatch = ((cfg_active ^ cfg_shadow) != SHADOW_MATCH);

  always_comb begin
    // Sticky until reset, so a passing upset still forces the reset
    next_parity_error = parity_error | (cfg_loaded & mismatch);
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      cfg_active <= CFG_RESET;
      cfg_shadow <= SHADOW_RESET;
      cfg_loaded <= 1'b0;
      parity_error <= 1'b0;
    end else begin
      cfg_active <= next_cfg_active;
      cfg_shadow <= next_cfg_shadow;
      cfg_loaded <= next_cfg_loaded;
      parity_error <= next_parity_error;
    end
  end

  // Access decision
  logic code_prot;
  logic write_prot;
  logic seg_block;
  logic is_write;
  logic global_block;

  assign is_write = ~REQ.read;
  assign code_prot = REQ.external & ~cfg_active.global_code_protect;
  assign write_prot = is_write & ~REQ.external & ~cfg_active.global_write_protect;
  // Last page holds the configuration source, so guard and segment shield it
  assign seg_block = is_write & segment_hit(cfg_active, page_of(REQ.addr), LAST_PAGE);
  assign global_block = code_prot | write_prot;

  always_comb begin
    // Fail safe: nothing passes before a clean configuration is loaded
    BLOCK = REQ.valid & (global_block | seg_block | ~cfg_loaded | parity_error);
  end

  assign CFG_VALID = cfg_loaded;
  assign CFG_ACTIVE = cfg_active;
  assign PARITY_ERROR = parity_error;
  assign FORCE_RESET = parity_error;

  // Checks
  logic req_page_last;
  logic req_page_ge;
  logic req_page_le;
  assign req_page_last = (page_of(REQ.addr) == LAST_PAGE);
  assign req_page_ge = (page_of(REQ.addr) >= page_idx_t'(cfg_active.segment_page_select));
  assign req_page_le = (page_of(REQ.addr) <= page_idx_t'(cfg_active.segment_page_select));

  property p_ext_code_protect;
    @(posedge SYS_CLK) disable iff (!NRST)
      (REQ.valid && REQ.external && !cfg_active.global_code_protect) |-> BLOCK;
  endproperty
  a_ext_code_protect: assert property (p_ext_code_protect) else $error("external access passed under code protect");

  property p_int_read_free;
    @(posedge SYS_CLK) disable iff (!NRST)
      (REQ.valid && REQ.read && !REQ.external && cfg_loaded && !parity_error) |-> !BLOCK;
  endproperty
  a_int_read_free: assert property (p_int_read_free) else $error("internal read blocked");

  property p_write_protect;
    @(posedge SYS_CLK) disable iff (!NRST)
      (REQ.valid && !REQ.read && !REQ.external && !cfg_active.global_write_protect) |-> BLOCK;
  endproperty
  a_write_protect: assert property (p_write_protect) else $error("internal write passed under write protect");

  property p_seg_low;
    @(posedge SYS_CLK) disable iff (!NRST)
      (REQ.valid && !REQ.read && !cfg_active.segment_protect_disable
        && !cfg_active.segment_direction && req_page_le) |-> BLOCK;
  endproperty
  a_seg_low: assert property (p_seg_low) else $error("write below boundary page passed");

  property p_seg_high;
    @(posedge SYS_CLK) disable iff (!NRST)
      (REQ.valid && !REQ.read && !cfg_active.segment_protect_disable
        && cfg_active.segment_direction && req_page_ge) |-> BLOCK;
  endproperty
  a_seg_high: assert property (p_seg_high) else $error("write above boundary page passed");

  property p_last_guard;
    @(posedge SYS_CLK) disable iff (!NRST)
      (REQ.valid && !REQ.read && !cfg_active.last_page_guard && req_page_last) |-> BLOCK;
  endproperty
  a_last_guard: assert property (p_last_guard) else $error("write to guarded last page passed");

  property p_no_segment;
    @(posedge SYS_CLK) disable iff (!NRST)
      (REQ.valid && !REQ.read && !REQ.external && cfg_loaded && !parity_error
        && cfg_active.segment_protect_disable && cfg_active.last_page_guard
        && cfg_active.global_write_protect) |-> !BLOCK;
  endproperty
  a_no_segment: assert property (p_no_segment) else $error("write blocked with no protection set");

  property p_seg_outside;
    @(posedge SYS_CLK) disable iff (!NRST)
      (REQ.valid && !REQ.read && !REQ.external && cfg_loaded && !parity_error
        && cfg_active.global_write_protect && !cfg_active.segment_protect_disable
        && cfg_active.segment_direction && !req_page_ge && !req_page_last) |-> !BLOCK;
  endproperty
  a_seg_outside: assert property (p_seg_outside) else $error("write outside segment blocked");

  property p_load_shadow;
    @(posedge SYS_CLK) disable iff (!NRST)
      (CFG_LOAD && !parity_error) |=> (CFG_VALID && CFG_ACTIVE == $past(CFG_WORD) && !mismatch);
  endproperty
  a_load_shadow: assert property (p_load_shadow) else $error("configuration load not mirrored in shadow");

  property p_upset_reset;
    @(posedge SYS_CLK) disable iff (!NRST)
      (cfg_loaded && mismatch) |=> (PARITY_ERROR && FORCE_RESET) [*4];
  endproperty
  a_upset_reset: assert property (p_upset_reset) else $error("shadow mismatch did not hold reset request");

  property p_error_blocks;
    @(posedge SYS_CLK) disable iff (!NRST)
      (parity_error && REQ.valid) |-> BLOCK;
  endproperty
  a_error_blocks: assert property (p_error_blocks) else $error("access passed after parity error");

  property p_idle_no_block;
    @(posedge SYS_CLK) disable iff (!NRST)
      !REQ.valid |-> !BLOCK;
  endproperty
  a_idle_no_block: assert property (p_idle_no_block) else $error("block raised with no request");

  property p_unloaded_blocks;
    @(posedge SYS_CLK) disable iff (!NRST)
      (REQ.valid && !cfg_loaded) |-> BLOCK;
  endproperty
  a_unloaded_blocks: assert property (p_unloaded_blocks) else $error("access passed before configuration load");

  property p_ext_read_free;
    @(posedge SYS_CLK) disable iff (!NRST)
      (REQ.valid && REQ.read && REQ.external && cfg_active.global_code_protect
        && cfg_loaded && !parity_error) |-> !BLOCK;
  endproperty
  a_ext_read_free: assert property (p_ext_read_free) else $error("external read blocked without code protect");

endmodule

// *** tb/nvm_requester.sv ***
/*
  Memory controller model: presents one request per start pulse.
  Assumes start and its fields change just after the clock rises.
*/
`timescale 1ns/10ps
module nvm_requester (
  input wire logic clk,
  input wire logic start,
  input wire logic ext,
  input wire logic rd,
  input wire logic [23:0] addr,
  output pm_guard_pkg::req_s req
);
  import pm_guard_pkg::*;
  always @(posedge clk) begin
    if (start) begin
      req <= '{valid: 1'b1, external: ext, read: rd, addr: addr};
    end else begin
      // Released lines flip so stale values never pass
      req <= '{valid: 1'b0, external: ~ext, read: ~rd, addr: ~addr};
    end
  end
endmodule

// *** tb/tb.sv ***
/*
  Bench for the write guard: reference model, random images and requests.
  Assumes nvm_requester drives the request port.
*/
`timescale 1ns/10ps
module tb;
  import pm_guard_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cfg_load = 1'b0;
  cfg_s cfg_word = '1;
  cfg_s cfg_upset = '0;
  logic start = 1'b0;
  logic ext = 1'b0;
  logic rd = 1'b0;
  logic [23:0] addr = '0;
  req_s req;
  logic block, cfg_valid, parity_error, force_reset;
  cfg_s cfg_active, c, w;
  int mismatches = 0;
  int n_checks = 0;
  int loaded = 0;
  int perr = 0;
  int sel;
  initial forever #10 clk = ~clk;
  program_memory_write_guard uut (.SYS_CLK(clk), .NRST(nrst), .CFG_LOAD(cfg_load), .CFG_WORD(cfg_word),
    .CFG_UPSET(cfg_upset), .REQ(req), .BLOCK(block), .CFG_VALID(cfg_valid), .CFG_ACTIVE(cfg_active),
    .PARITY_ERROR(parity_error), .FORCE_RESET(force_reset));
  nvm_requester host (.clk(clk), .start(start), .ext(ext), .rd(rd), .addr(addr), .req(req));
  function automatic int model(int x, int r, int p);
    if (loaded == 0 || perr != 0) return 1;
    if (x != 0 && c.global_code_protect == 1'b0) return 1;
    if (r != 0) return 0;
    if (x == 0 && c.global_write_protect == 1'b0) return 1;
    if (c.segment_protect_disable == 1'b0) begin
      if (c.segment_direction ? p >= sel : p <= sel) return 1;
    end
    return (c.last_page_guard == 1'b0 && p == int'(LAST_PAGE_DEFAULT)) ? 1 : 0;
  endfunction
  task automatic check_bit(string what, logic exp, logic got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_image(cfg_s exp, cfg_s got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch cfg_active expected %h seen %h", exp, got);
    end
  endtask
  task automatic access(int x, int r, int p);
    int e;
    @(posedge clk) #1;
    start = 1'b1;
    ext = x[0];
    rd = r[0];
    addr = {p[14:0], 9'($urandom)};
    e = model(x, r, p);
    @(posedge clk) #1;
    start = 1'b0;
    #4 check_bit("block", e[0], block);
  endtask
  task automatic load(cfg_s v);
    @(posedge clk) #1;
    cfg_load = 1'b1;
    cfg_word = v;
    @(posedge clk) #1;
    cfg_load = 1'b0;
    c = v;
    sel = int'(v.segment_page_select);
    loaded = 1;
    check_bit("cfg_valid", 1'b1, cfg_valid);
    check_image(v, cfg_active);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Run needs about 3600 cycles; margin for slow handshakes
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h59BF));
    repeat (8) @(posedge clk);
    #1 nrst = 1'b1;
    check_bit("cfg_valid", 1'b0, cfg_valid);
    check_image(14'h3FFF, cfg_active);
    check_bit("idle", 1'b0, block);
    access(0, 1, 0);
    $display("test reset done");
    for (int i = 0; i < 256; i++) begin
      w = cfg_s'(14'($urandom));
      {w.segment_protect_disable, w.segment_direction, w.last_page_guard} = i[2:0];
      load(w);
      for (int k = 0; k < 6; k++) begin
        access($urandom % 2, $urandom % 2, (k == 5) ? 32'h1FF : (sel + k - 2) & 32'h1FF);
      end
    end
    $display("test segment done");
    load(14'h3FFF);
    access(0, 0, 0);
    @(posedge clk) #1;
    cfg_upset = 14'h0001;
    @(posedge clk) #1;
    cfg_upset = '0;
    check_image(14'h3FFE, cfg_active);
    check_bit("parity_error", 1'b0, parity_error);
    @(posedge clk) #1;
    check_bit("parity_error", 1'b1, parity_error);
    check_bit("force_reset", 1'b1, force_reset);
    perr = 1;
    access(0, 1, 3);
    @(posedge clk) #1;
    nrst = 1'b0;
    @(posedge clk) #1;
    nrst = 1'b1;
    perr = 0;
    loaded = 0;
    check_bit("parity_error", 1'b0, parity_error);
    access(0, 1, 3);
    $display("test parity done");
    give_verdict();
  end
endmodule
